/* src/fir_defs.vh */
// Purpose : Constants for the flash identifier/status read controller
// Assumes : Command codes and offsets are plain defaults, changeable here
// Notes   : Host side; the flash itself lives outside this design
`ifndef FIR_DEFS_VH
`define FIR_DEFS_VH

// ----------------------------------------
// Software register offsets (word index)
// ----------------------------------------
`define FIR_REG_CMD        4'h0
`define FIR_REG_ADDR       4'h1
`define FIR_REG_RDATA      4'h2
`define FIR_REG_STATUS     4'h3
`define FIR_REG_IRQ        4'h4
`define FIR_REG_MASK       4'h5
`define FIR_REG_STATE      4'h6

// ----------------------------------------
// Orders written to the command register
// ----------------------------------------
`define FIR_OP_ID          8'h01
`define FIR_OP_STATUS      8'h02
`define FIR_OP_READ        8'h03
`define FIR_OP_ARRAY       8'h04

// ----------------------------------------
// Flash command bytes
// ----------------------------------------
`define FIR_FCMD_ID        8'h90
`define FIR_FCMD_STATUS    8'h70
`define FIR_FCMD_ARRAY     8'hFF

// ----------------------------------------
// Identifier and query locations
// ----------------------------------------
`define FIR_ID_MFR         24'h00_0000
`define FIR_ID_DEV         24'h00_0001
`define FIR_ID_LOCK        24'h00_0002
`define FIR_CFI_PAGE       24'h00_0044
`define FIR_CFI_SYNC       24'h00_0045
`define FIR_PAGE_EXP       8'h03
`define FIR_SYNC_FIELDS    8'h00

// ----------------------------------------
// Status byte fields
// ----------------------------------------
`define FIR_SR_READY       7
`define FIR_SR_ERASE_SUSP  6
`define FIR_SR_ERASE_ERR   5
`define FIR_SR_PROG_ERR    4
`define FIR_SR_SUPPLY_ERR  3
`define FIR_SR_PROG_SUSP   2
`define FIR_SR_PROTECT_ERR 1

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define FIR_IRQ_DONE       0
`define FIR_IRQ_READY      1
`define FIR_IRQ_ERROR      2

// ----------------------------------------
// Timing: access time 120 ns, recovery 30 ns at 8 ns clock
// ----------------------------------------
`define FIR_CLK_NS         8
`define FIR_ACCESS_NS      120
`define FIR_RECOVER_NS     30
`define FIR_ACCESS_CYC     ((`FIR_ACCESS_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`define FIR_RECOVER_CYC    ((`FIR_RECOVER_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)

`endif

/* src/fir_host.v */
// Purpose : Host controller that drives a parallel NOR flash in identifier and status modes
// Assumes : x16 flash data bus; one clock; software port with read data one cycle later
// Notes   : Every output comes from a flip-flop
//
// Notes on behaviour
// - Identifier command enters identifier mode returning maker, device and lock codes.
// - Identifier mode lasts until another valid command is written.
// - Identifier command only issued when controller is idle or suspended.
// - Read-status command may be written at any time, busy or finished.
// - Host raises output enable or deselects between reads to refresh status.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "fir_defs.vh"

module fir_host #(
   parameter ADDR_W = 24,
   parameter ACCESS = `FIR_ACCESS_CYC,
   parameter RECOVER = `FIR_RECOVER_CYC
) (
   input  wire              i_clk,
   input  wire              i_reset_n,
   input  wire [3:0]        i_addr,
   input  wire [31:0]       i_wdata,
   input  wire              i_wr,
   input  wire              i_rd,
   output reg  [31:0]       o_rdata,
   output reg               o_irq,
   output reg  [ADDR_W-1:0] o_flash_addr,
   output reg  [15:0]       o_flash_dq,
   output reg               o_flash_dq_oe_n,
   input  wire [15:0]       i_flash_dq,
   output reg               o_flash_ce_n,
   output reg               o_flash_oe_n,
   output reg               o_flash_we_n,
   output reg               o_flash_program_enable_supply
);

   // ----------------------------------------
   // States and modes
   // ----------------------------------------
   localparam [4:0] S_IDLE  = 5'b0_0001;
   localparam [4:0] S_WRITE = 5'b0_0010;
   localparam [4:0] S_READ  = 5'b0_0100;
   localparam [4:0] S_RECOV = 5'b0_1000;
   localparam [4:0] S_DONE  = 5'b1_0000;
   localparam [1:0] M_ARRAY = 2'h0;
   localparam [1:0] M_ID    = 2'h1;
   localparam [1:0] M_STAT  = 2'h2;

   reg [4:0]        state;
   reg [1:0]        mode;
   reg [7:0]        count;
   reg [7:0]        wcmd;
   reg              is_read;
   reg [ADDR_W-1:0] addr_reg;
   reg [15:0]       rdata;
   reg [7:0]        status;
   reg              status_ok;
   reg [2:0]        irq_stat;
   reg [2:0]        irq_mask;
   reg              last_ready;
   reg [7:0]        dev_cmd;
   reg [2:0]        ev;
   wire             id_ok;

   // Identifier command refused only while a status read shows busy and not suspended
   assign id_ok = !(status_ok && !status[`FIR_SR_READY] &&
                    !status[`FIR_SR_ERASE_SUSP] && !status[`FIR_SR_PROG_SUSP]);

   // Word address used for an identifier read: bit 1 of byte address is lowest line
   function [ADDR_W-1:0] id_addr;
      input [ADDR_W-1:0] a;
      begin
         id_addr = {a[ADDR_W-2:0], 1'b0};
      end
   endfunction

   // ----------------------------------------
   // Sequencer: command writes and single reads
   // ----------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state           <= S_IDLE;
         mode            <= M_ARRAY;
         count           <= 8'h00;
         wcmd            <= 8'h00;
         is_read         <= 1'b0;
         addr_reg        <= {ADDR_W{1'b0}};
         rdata           <= 16'h0000;
         status          <= 8'h00;
         status_ok       <= 1'b0;
         o_flash_addr    <= {ADDR_W{1'b0}};
         o_flash_dq      <= 16'h0000;
         o_flash_dq_oe_n <= 1'b1;
         o_flash_ce_n    <= 1'b1;
         o_flash_oe_n    <= 1'b1;
         o_flash_we_n    <= 1'b1;
         o_flash_program_enable_supply <= 1'b0;
         ev              <= 3'h0;
      end else begin
         ev <= 3'h0;
         if (i_wr && i_addr == `FIR_REG_ADDR) begin
            addr_reg <= i_wdata[ADDR_W-1:0];
         end
         case (state)
            S_IDLE: begin
               if (i_wr && i_addr == `FIR_REG_CMD) begin
                  if (i_wdata[7:0] == `FIR_OP_READ) begin
                     // One access per read, never a page burst
                     is_read      <= 1'b1;
                     o_flash_addr <= (mode == M_ID) ? id_addr(addr_reg) : addr_reg;
                     o_flash_ce_n <= 1'b0;
                     o_flash_oe_n <= 1'b0;
                     count        <= 8'h00;
                     state        <= S_READ;
                  end else if (i_wdata[7:0] == `FIR_OP_ID && id_ok) begin
                     // Supply pin left low: identifier works regardless
                     wcmd  <= `FIR_FCMD_ID;
                     state <= S_WRITE;
                  end else if (i_wdata[7:0] == `FIR_OP_STATUS) begin
                     wcmd  <= `FIR_FCMD_STATUS;
                     state <= S_WRITE;
                  end else if (i_wdata[7:0] == `FIR_OP_ARRAY) begin
                     wcmd  <= `FIR_FCMD_ARRAY;
                     state <= S_WRITE;
                  end
                  // A refused identifier order leaves the strobes untouched
                  if ((i_wdata[7:0] == `FIR_OP_ID && id_ok) || i_wdata[7:0] == `FIR_OP_STATUS ||
                      i_wdata[7:0] == `FIR_OP_ARRAY) begin
                     is_read         <= 1'b0;
                     o_flash_addr    <= addr_reg;
                     o_flash_dq      <= {8'h00, (i_wdata[7:0] == `FIR_OP_ID) ? `FIR_FCMD_ID :
                                        (i_wdata[7:0] == `FIR_OP_STATUS) ? `FIR_FCMD_STATUS : `FIR_FCMD_ARRAY};
                     o_flash_dq_oe_n <= 1'b0;
                     o_flash_ce_n    <= 1'b0;
                     o_flash_we_n    <= 1'b0;
                     count           <= 8'h00;
                  end
               end
            end
            S_WRITE: begin
               if (count == ACCESS[7:0] - 8'h01) begin
                  o_flash_we_n <= 1'b1;
                  o_flash_ce_n <= 1'b1;
                  count        <= 8'h00;
                  state        <= S_RECOV;
                  // Any other valid command ends identifier or status mode
                  mode <= (wcmd == `FIR_FCMD_ID) ? M_ID :
                          (wcmd == `FIR_FCMD_STATUS) ? M_STAT : M_ARRAY;
               end else begin
                  count <= count + 8'h01;
               end
            end
            S_READ: begin
               if (count == ACCESS[7:0] - 8'h01) begin
                  if (mode == M_STAT) begin
                     status_ok <= 1'b1;
                     // While busy only the ready bit is trusted; the rest floats
                     if (!i_flash_dq[`FIR_SR_READY]) begin
                        status <= {i_flash_dq[`FIR_SR_READY], 7'h00};
                        rdata  <= {8'h00, i_flash_dq[`FIR_SR_READY], 7'h00};
                     end else begin
                        status <= i_flash_dq[7:0];
                        rdata  <= {8'h00, i_flash_dq[7:0]};
                     end
                  end else if (mode == M_ID) begin
                     rdata <= {8'h00, i_flash_dq[7:0]};
                  end else begin
                     rdata <= i_flash_dq;
                  end
                  // Output enable high before any further read refreshes the latch
                  o_flash_oe_n <= 1'b1;
                  o_flash_ce_n <= 1'b1;
                  count        <= 8'h00;
                  state        <= S_RECOV;
               end else begin
                  count <= count + 8'h01;
               end
            end
            S_RECOV: begin
               o_flash_dq_oe_n <= 1'b1;
               if (count >= RECOVER[7:0] - 8'h01) begin
                  state <= S_DONE;
               end else begin
                  count <= count + 8'h01;
               end
            end
            S_DONE: begin
               ev[`FIR_IRQ_DONE]  <= 1'b1;
               ev[`FIR_IRQ_READY] <= is_read && mode == M_STAT && status[`FIR_SR_READY] && !last_ready;
               ev[`FIR_IRQ_ERROR] <= is_read && mode == M_STAT && status[`FIR_SR_READY] &&
                                     (|status[`FIR_SR_ERASE_ERR:`FIR_SR_SUPPLY_ERR] | status[`FIR_SR_PROTECT_ERR]);
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Interrupt status, mask and read port
   // ----------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         irq_stat   <= 3'h0;
         irq_mask   <= 3'h0;
         last_ready <= 1'b1;
         o_rdata    <= 32'h0000_0000;
         o_irq      <= 1'b0;
         dev_cmd    <= 8'h00;
      end else begin
         if (ev[`FIR_IRQ_DONE] && is_read && mode == M_STAT) begin
            last_ready <= status[`FIR_SR_READY];
         end
         dev_cmd <= wcmd;
         // Set wins over the clear caused by reading
         irq_stat <= ((i_rd && i_addr == `FIR_REG_IRQ) ? 3'h0 : irq_stat) | ev;
         if (i_wr && i_addr == `FIR_REG_MASK) begin
            irq_mask <= i_wdata[2:0];
         end
         o_irq <= |((irq_stat | ev) & irq_mask);
         if (i_rd) begin
            if (i_addr == `FIR_REG_RDATA) begin
               o_rdata <= {16'h0000, rdata};
            end else if (i_addr == `FIR_REG_ADDR) begin
               o_rdata <= {{(32-ADDR_W){1'b0}}, addr_reg};
            end else if (i_addr == `FIR_REG_STATUS) begin
               o_rdata <= {23'h00_0000, status_ok, status};
            end else if (i_addr == `FIR_REG_IRQ) begin
               o_rdata <= {29'h0000_0000, irq_stat};
            end else if (i_addr == `FIR_REG_MASK) begin
               o_rdata <= {29'h0000_0000, irq_mask};
            end else if (i_addr == `FIR_REG_STATE) begin
               o_rdata <= {17'h0_0000, dev_cmd, mode, state};
            end else begin
               o_rdata <= 32'h0000_0000;
            end
         end else begin
            o_rdata <= 32'h0000_0000;
         end
      end
   end

endmodule

/* testbench/fir_flash_model.sv */
// Purpose : Behavioural x16 parallel NOR flash for query, identifier and status reads
// Assumes : Strobes active low; one access at a time
// Notes   : Lines no party drives show the inverse of the last value
`timescale 1ns/10ps
`include "fir_defs.vh"
module fir_flash_model #(
   parameter MFR_CODE = 8'h5C,  // Arbitrary value
   parameter DEV_CODE = 8'h3E   // Arbitrary value
) (
   input  wire        i_ce_n,
   input  wire        i_oe_n,
   input  wire        i_we_n,
   input  wire [23:0] i_addr,
   input  wire [15:0] i_dq,
   input  wire        i_busy,
   input  wire [6:0]  i_sr_bits,
   output reg  [15:0] o_dq
);
   reg  [1:0]  mode   = 2'd0;       // 0 array, 1 identifier, 2 status
   reg  [15:0] sr_lat = 16'h0000;
   reg  [15:0] rel    = 16'h6C93;
   wire [22:0] w      = i_addr[23:1];
   wire        susp   = i_sr_bits[6] | i_sr_bits[2];
   reg  [7:0]  cmd_lat = 8'h00;
   // Command byte held while both strobes are low, so a joint release cannot race
   always @*
      if (!i_ce_n && !i_we_n)
         cmd_lat = i_dq[7:0];
   // Command decode on write strobe rise, supply level ignored
   always @(posedge i_we_n) begin
      if (cmd_lat == `FIR_FCMD_ID && (!i_busy || susp))
         mode <= 2'd1;
      else if (cmd_lat == `FIR_FCMD_STATUS)
         mode <= 2'd2;
      else if (cmd_lat == `FIR_FCMD_ARRAY)
         mode <= 2'd0;
   end
   // Status latched on enabling edge; busy leaves other lines floating
   always @(negedge i_oe_n or negedge i_ce_n)
      sr_lat <= i_busy ? 16'hA55A : {8'h00, 1'b1, i_sr_bits};
   // Released bus shows inverse of the last value
   always @(posedge i_oe_n)
      rel <= ~o_dq;
   // One code per access, no paging
   always @* begin
      if (i_ce_n || i_oe_n)
         o_dq = rel;
      else if (mode == 2'd2)
         o_dq = sr_lat;
      else if (mode == 2'd1)
         o_dq = (w[15:0] == 16'h0000) ? {8'h00, MFR_CODE} : (w[15:0] == 16'h0001) ? {8'h00, DEV_CODE} :
                (w[15:0] == 16'h0002) ? {15'h0000, w[16]} : 16'h0000;
      else
         o_dq = (i_addr == 24'h00_0044) ? 16'h0003 : (i_addr == 24'h00_0045) ? 16'h0000 : ~i_addr[15:0];
   end
endmodule

/* testbench/fir_host_chk.sv */
// Purpose : Port-level checks of the flash host controller
// Assumes : Sees only top-level ports
// Notes   : Bound into every fir_host instance
`timescale 1ns/10ps
`include "fir_defs.vh"
module fir_host_chk #(
   parameter ADDR_W  = 24,
   parameter ACCESS  = 15,
   parameter RECOVER = 4
) (
   input wire              i_clk,
   input wire              i_reset_n,
   input wire              i_rd,
   input wire [31:0]       o_rdata,
   input wire [ADDR_W-1:0] o_flash_addr,
   input wire [15:0]       o_flash_dq,
   input wire              o_flash_dq_oe_n,
   input wire [15:0]       i_flash_dq,
   input wire              o_flash_ce_n,
   input wire              o_flash_oe_n,
   input wire              o_flash_we_n
);
   reg [7:0] lo_cnt;
   reg [7:0] hi_cnt;
   reg [7:0] last_cmd;
   reg [7:0] last_sr;
   // Strobe widths, last command and last status byte seen
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lo_cnt <= 8'h00;
         hi_cnt <= 8'h00;
         last_cmd <= 8'h00;
         last_sr <= 8'h80;
      end else begin
         lo_cnt <= o_flash_oe_n ? 8'h00 : lo_cnt + 8'h01;
         hi_cnt <= !o_flash_ce_n ? 8'h00 : (hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01;
         if (!o_flash_we_n)
            last_cmd <= o_flash_dq[7:0];
         if ($rose(o_flash_oe_n) && last_cmd == `FIR_FCMD_STATUS)
            last_sr <= $past(i_flash_dq[7:0]);
      end
   end
   AST_OE_WIDTH: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_flash_oe_n) |-> lo_cnt == ACCESS) else $error("Output enable low time wrong");
   AST_RECOVER: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $fell(o_flash_ce_n) |-> hi_cnt >= RECOVER) else $error("Chip enable recovery too short");
   AST_SAME_EDGE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      $fell(o_flash_oe_n) |-> $fell(o_flash_ce_n) && o_flash_we_n && o_flash_dq_oe_n) else $error("Read start bad");
   AST_ADDR_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !o_flash_oe_n && !$past(o_flash_oe_n) |-> $stable(o_flash_addr)) else $error("Address moved in a read");
   AST_CMD_DRIVE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !o_flash_we_n |-> !o_flash_dq_oe_n && !o_flash_ce_n && o_flash_oe_n) else $error("Command write bad");
   AST_ID_ADDR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !o_flash_oe_n && last_cmd == `FIR_FCMD_ID |-> !o_flash_addr[0]) else $error("Identifier address bit 0 set");
   AST_ID_GUARD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !o_flash_we_n && o_flash_dq[7:0] == `FIR_FCMD_ID |-> last_sr[7]) else $error("Identifier sent while busy");
   AST_RDATA_SLOT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      o_rdata != 32'h0000_0000 |-> $past(i_rd)) else $error("Read data outside its slot");
endmodule
bind fir_host fir_host_chk #(.ADDR_W(ADDR_W), .ACCESS(ACCESS), .RECOVER(RECOVER)) i_fir_host_chk (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_rd(i_rd), .o_rdata(o_rdata), .o_flash_addr(o_flash_addr),
   .o_flash_dq(o_flash_dq), .o_flash_dq_oe_n(o_flash_dq_oe_n), .i_flash_dq(i_flash_dq),
   .o_flash_ce_n(o_flash_ce_n), .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n));

/* testbench/tb.sv */
// Purpose : Register-level test of the flash host controller against a flash model
// Assumes : Short access and recovery counts
// Notes   : Codes are arbitrary values
`timescale 1ns/10ps
`include "fir_defs.vh"
module tb;
   localparam MFR = 8'h5C;  // Arbitrary value
   localparam DEV = 8'h3E;  // Arbitrary value
   reg         i_clk = 1'b0;
   reg         i_reset_n = 1'b0;
   reg  [3:0]  i_addr = 4'h0;
   reg  [31:0] i_wdata = 32'h0000_0000;
   reg         i_wr = 1'b0;
   reg         i_rd = 1'b0;
   reg         busy = 1'b0;
   wire [31:0] o_rdata;
   wire        o_irq, ce_n, oe_n, we_n, dq_oe_n, supply;
   wire [23:0] faddr;
   wire [15:0] hdq, mdq;
   wire [15:0] fdq = dq_oe_n ? mdq : hdq;  // Resolved data wire
   integer     miscompares = 0;
   integer     n_compared = 0;
   reg  [31:0] d;
   always #4 i_clk = ~i_clk;
   fir_host #(.ADDR_W(24), .ACCESS(4), .RECOVER(2)) i_fir_host (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
      .o_flash_addr(faddr), .o_flash_dq(hdq), .o_flash_dq_oe_n(dq_oe_n), .i_flash_dq(fdq), .o_flash_ce_n(ce_n),
      .o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_program_enable_supply(supply));
   fir_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_fir_flash_model (.i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_addr(faddr), .i_dq(hdq), .i_busy(busy), .i_sr_bits(7'h2A), .o_dq(mdq));
   // ----------------------------------------
   // Bus tasks and comparison
   // ----------------------------------------
   task report_and_stop;
      begin
         if (miscompares == 0 && n_compared > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input string what, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task wr(input [3:0] a, input [31:0] v);
      begin
         @(posedge i_clk);
         i_wr <= 1'b1;
         i_addr <= a;
         i_wdata <= v;
         @(posedge i_clk);
         i_wr <= 1'b0;
      end
   endtask
   task rd(input [3:0] a);
      begin
         @(posedge i_clk);
         i_rd <= 1'b1;
         i_addr <= a;
         @(posedge i_clk);
         i_rd <= 1'b0;
         #1 d = o_rdata;
      end
   endtask
   task idle;
      integer k;
      begin
         d = 32'h0000_0000;
         for (k = 0; k < 100 && d[4:0] !== 5'h01; k = k + 1)
            rd(`FIR_REG_STATE);
         if (d[4:0] !== 5'h01) begin
            miscompares = miscompares + 1;
            report_and_stop;
         end
      end
   endtask
   task op(input [7:0] code, input [31:0] a);
      begin
         wr(`FIR_REG_ADDR, a);
         wr(`FIR_REG_CMD, {24'h00_0000, code});
         idle;
      end
   endtask
   task rdf(input [31:0] a, input [31:0] exp);
      begin
         op(`FIR_OP_READ, a);
         rd(`FIR_REG_RDATA);
         chk("flash_data", d, exp);
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      wr(`FIR_REG_MASK, 32'h0000_0001);
      rd(`FIR_REG_MASK);
      chk("mask", d, 32'h0000_0001);
      rd(4'hF);
      chk("unmapped", d, 32'h0000_0000);
      op(`FIR_OP_ARRAY, 32'h0000_0000);
      chk("irq_high", {31'h0, o_irq}, 32'h0000_0001);
      rd(`FIR_REG_IRQ);
      chk("irq_done", d & 32'h0000_0001, 32'h0000_0001);
      rd(`FIR_REG_IRQ);
      chk("irq_cleared", d, 32'h0000_0000);
      wr(`FIR_REG_MASK, 32'h0000_0000);
      rdf(32'h0000_0044, 32'h0000_0003);
      rdf(32'h0000_0045, 32'h0000_0000);
      chk("irq_masked", {31'h0, o_irq}, 32'h0000_0000);
      op(`FIR_OP_ID, 32'h0000_0000);
      rdf(32'h0000_0000, {24'h00_0000, MFR});
      rdf(32'h0000_0001, {24'h00_0000, DEV});
      rdf(32'h0000_0002, 32'h0000_0000);
      rdf(32'h0001_0002, 32'h0000_0001);
      rdf(32'h0000_0000, {24'h00_0000, MFR});
      op(`FIR_OP_STATUS, 32'h0000_0000);
      rdf(32'h0000_0000, 32'h0000_00AA);
      busy <= 1'b1;
      rdf(32'h0000_0000, 32'h0000_0000);
      rd(`FIR_REG_STATUS);
      chk("status_busy", {24'h00_0000, d[7:0]}, 32'h0000_0000);
      wr(`FIR_REG_CMD, {24'h00_0000, `FIR_OP_ID});
      idle;
      rd(`FIR_REG_STATE);
      chk("mode_kept", {30'h0, d[6:5]}, 32'h0000_0002);
      busy <= 1'b0;
      rdf(32'h0000_0000, 32'h0000_00AA);
      wr(`FIR_REG_MASK, 32'h0000_0006);
      rd(`FIR_REG_IRQ);
      chk("irq_events", d, 32'h0000_0007);
      chk("irq_unmasked", {31'h0, o_irq}, 32'h0000_0001);
      rd(`FIR_REG_IRQ);
      chk("irq_events_clear", d, 32'h0000_0000);
      chk("irq_off", {31'h0, o_irq}, 32'h0000_0000);
      op(`FIR_OP_ID, 32'h0000_0000);
      rdf(32'h0000_0001, {24'h00_0000, DEV});
      chk("supply", {31'h0, supply}, 32'h0000_0000);
      report_and_stop;
   end
endmodule
